/* hw/ccs_pkg.sv */
package ccs_pkg;
	// Coprocessor command decode
	localparam logic [3:0] CCS_SYS_REG_NUM = 4'hF;
	localparam logic [2:0] CCS_OPC2_CLKSW = 3'h2;
	localparam logic [3:0] CCS_CRM_ENABLE = 4'h1;
	localparam logic [3:0] CCS_CRM_DISABLE = 4'h2;
	// Frequency select field
	localparam int CCS_FREQ_W = 5;
	localparam logic [CCS_FREQ_W-1:0] CCS_FREQ_RST = 5'h00;
	// Output clock phase counter: bit 0 is the fast clock, bit 1 the memory clock
	localparam int CCS_PHASE_W = 2;
	localparam logic [CCS_PHASE_W-1:0] CCS_PHASE_WRAP = 2'h0;
	localparam int CCS_FAST_BIT = 0;
	localparam int CCS_MEM_BIT = 1;

	typedef enum logic [1:0] {
		CCS_SRC_FAST = 2'b01,
		CCS_SRC_MEM = 2'b10
	} ccs_src_e;

	// One system coprocessor register write from the core
	typedef struct packed {
		logic valid;
		logic [3:0] reg_num;
		logic [2:0] opc2;
		logic [3:0] coprocessor_reg_modifier;
	} ccs_cp_wr_s;
endpackage : ccs_pkg

/* hw/ccs_core_clock_switch.sv */
`timescale 1ns/100ps
// Functional notes
// - Core working clock comes from fast core clock or half-rate memory clock.
// - Fast core clock rate is set by the five-bit core_freq_select field.
// - With switching on, use fast clock except while cache fills are pending.
// - Reset leaves switching disabled and the memory clock driving the core.
// - Coprocessor 15 write, second opcode 2, modifier 2, disables switching.
// - Coprocessor 15 write, second opcode 2, modifier 1, enables switching.
// - Disabling only freezes the source; it does not force the memory clock.
// - A cache miss after disabling moves to memory clock, which then stays.
module ccs_core_clock_switch
	import ccs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [CCS_FREQ_W-1:0] core_freq_select,
	input wire ccs_cp_wr_s cp_wr,
	input wire logic cache_fill_pending,
	output logic core_working_clock,
	output logic clk_src_is_mem,
	output logic switching_enabled
);

	// The output clock is built from a two-bit phase count that advances once per divider tick.
	// Bit 0 of the count toggles at the fast rate and bit 1 at the memory rate, so the memory
	// clock is always exactly half the fast one and both share the wrap point.
	// Limitation: a new frequency setting or source waits for the next wrap, up to four ticks away.

	// Decode of a clock-switch write from the system control coprocessor
	function automatic logic cp_match(input ccs_cp_wr_s w, input logic [3:0] coprocessor_reg_modifier);
		logic reg_ok;
		logic opc_ok;
		logic crm_ok;

		reg_ok = (w.reg_num == CCS_SYS_REG_NUM);
		opc_ok = (w.opc2 == CCS_OPC2_CLKSW);
		crm_ok = (w.coprocessor_reg_modifier == coprocessor_reg_modifier);
		cp_match = w.valid && reg_ok && opc_ok && crm_ok;
	endfunction : cp_match

	// Phase count one step on; the two-bit count wraps by itself
	function automatic logic [CCS_PHASE_W-1:0] phase_step(input logic [CCS_PHASE_W-1:0] phase);
		logic [CCS_PHASE_W-1:0] step;

		step = CCS_PHASE_W'(phase + 1'b1);
		phase_step = step;
	endfunction : phase_step

	// Level of the output clock for one source at one phase
	function automatic logic src_level(input ccs_src_e src, input logic [CCS_PHASE_W-1:0] phase);
		logic level;

		level = 1'b0;
		unique case (src)
			CCS_SRC_FAST: begin
				level = phase[CCS_FAST_BIT];
			end
			CCS_SRC_MEM: begin
				level = phase[CCS_MEM_BIT];
			end
			default: begin
				level = 1'b0;
			end
		endcase
		src_level = level;
	endfunction : src_level

	// Source the policy asks for; it is only applied at the next wrap
	function automatic ccs_src_e pick_src(input logic sw_en, input logic force_mem, input logic fill,
		input ccs_src_e cur);
		ccs_src_e pick;

		pick = cur;
		if (sw_en) begin
			pick = fill ? CCS_SRC_MEM : CCS_SRC_FAST;
		end else if (force_mem) begin
			pick = CCS_SRC_MEM;
		end else begin
			// Disabling only freezes the source, wherever it stands
			pick = cur;
		end
		pick_src = pick;
	endfunction : pick_src

	// Divider state
	logic [CCS_FREQ_W-1:0] div_ff;
	logic [CCS_FREQ_W-1:0] nxt_div;
	logic [CCS_FREQ_W-1:0] freq_ff;
	logic [CCS_FREQ_W-1:0] nxt_freq;
	logic tick;
	logic wrap;

	// Output clock state
	logic [CCS_PHASE_W-1:0] phase_ff;
	logic [CCS_PHASE_W-1:0] nxt_phase;
	logic clk_out_ff;
	logic nxt_clk_out;
	ccs_src_e src_ff;
	ccs_src_e nxt_src;
	logic src_is_mem_ff;
	logic nxt_src_is_mem;

	// Switching control state
	logic sw_en_ff;
	logic nxt_sw_en;
	logic force_mem_ff;
	logic nxt_force_mem;
	logic fill_prev_ff;
	logic nxt_fill_prev;
	logic cmd_enable;
	logic cmd_disable;
	logic miss_seen;
	ccs_src_e want_src;

	// Divider: one tick every freq_ff + 1 system clocks
	always_comb begin
		tick = (div_ff == freq_ff);
		wrap = tick && (phase_step(phase_ff) == CCS_PHASE_WRAP);

		nxt_div = div_ff;
		nxt_freq = freq_ff;

		if (tick) begin
			nxt_div = '0;
		end else begin
			nxt_div = CCS_FREQ_W'(div_ff + 1'b1);
		end
		// Taking the setting only at a wrap keeps every half period whole
		if (wrap) begin
			nxt_freq = core_freq_select;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_ff <= '0;
			freq_ff <= CCS_FREQ_RST;
		end else begin
			div_ff <= nxt_div;
			freq_ff <= nxt_freq;
		end
	end

	// Phase count, source and output clock
	always_comb begin
		nxt_phase = phase_ff;
		nxt_clk_out = clk_out_ff;
		nxt_src = src_ff;

		if (tick) begin
			nxt_phase = phase_step(phase_ff);
		end

		// At the wrap both clocks have just fallen, so a swap cannot cut a phase short
		if (wrap) begin
			nxt_src = want_src;
		end

		if (tick) begin
			nxt_clk_out = src_level(nxt_src, nxt_phase);
		end
		nxt_src_is_mem = (nxt_src == CCS_SRC_MEM);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			phase_ff <= CCS_PHASE_WRAP;
			clk_out_ff <= 1'b0;
			src_ff <= CCS_SRC_MEM;
			src_is_mem_ff <= 1'b1;
		end else begin
			phase_ff <= nxt_phase;
			clk_out_ff <= nxt_clk_out;
			src_ff <= nxt_src;
			src_is_mem_ff <= nxt_src_is_mem;
		end
	end

	// An enable clears any forced memory clock unless a miss comes in the same cycle; a disable leaves the source where it is.
	// A miss while switching is off forces the memory clock until the next enable.
	always_comb begin
		cmd_enable = cp_match(cp_wr, CCS_CRM_ENABLE);
		cmd_disable = cp_match(cp_wr, CCS_CRM_DISABLE);

		// A miss shows as the rising edge of the fill-pending level
		miss_seen = cache_fill_pending && !fill_prev_ff;

		nxt_sw_en = sw_en_ff;
		nxt_force_mem = force_mem_ff;
		nxt_fill_prev = cache_fill_pending;

		if (cmd_enable) begin
			nxt_sw_en = 1'b1;
			nxt_force_mem = 1'b0;
		end else if (cmd_disable) begin
			nxt_sw_en = 1'b0;
		end
		// A miss in the cycle of an enable still sets the flag, so it is never lost
		if (!sw_en_ff && miss_seen) begin
			nxt_force_mem = 1'b1;
		end

		want_src = pick_src(sw_en_ff, force_mem_ff, cache_fill_pending, src_ff);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sw_en_ff <= 1'b0;
			force_mem_ff <= 1'b0;
			fill_prev_ff <= 1'b0;
		end else begin
			sw_en_ff <= nxt_sw_en;
			force_mem_ff <= nxt_force_mem;
			fill_prev_ff <= nxt_fill_prev;
		end
	end

	// Outputs come straight from registers so the core never sees a decode glitch
	assign core_working_clock = clk_out_ff;
	assign clk_src_is_mem = src_is_mem_ff;
	assign switching_enabled = sw_en_ff;

endmodule : ccs_core_clock_switch

/* bench/ccs_core_model.sv */
`timescale 1ns/100ps
module ccs_core_model
	import ccs_pkg::*;
(
	input wire logic clk_sys,
	output ccs_cp_wr_s cp_wr,
	output logic cache_fill_pending
);
	initial cp_wr = '0;
	initial cache_fill_pending = 1'h0;
	task wr(input logic [3:0] rn, input logic [3:0] m);
		@(negedge clk_sys) cp_wr = {1'h1, rn, CCS_OPC2_CLKSW, m};
		@(negedge clk_sys) cp_wr = '0;
	endtask : wr
	task fill(input logic v);
		@(negedge clk_sys) cache_fill_pending = v;
	endtask : fill
endmodule : ccs_core_model

/* bench/ccs_core_clock_switch_assertions.sv */
`timescale 1ns/100ps
module ccs_chk
	import ccs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire ccs_cp_wr_s cp_wr,
	input wire logic cache_fill_pending,
	input wire logic core_working_clock,
	input wire logic clk_src_is_mem,
	input wire logic switching_enabled
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic hit = cp_wr.valid && cp_wr.reg_num == CCS_SYS_REG_NUM && cp_wr.opc2 == CCS_OPC2_CLKSW;
	a_reset_state: assert property ($fell(sys_rst) |-> clk_src_is_mem && !switching_enabled) else $error("rst");
	a_en_write: assert property (hit && cp_wr.coprocessor_reg_modifier == CCS_CRM_ENABLE |=> switching_enabled) else $error("en");
	a_dis_write: assert property (hit && cp_wr.coprocessor_reg_modifier == CCS_CRM_DISABLE |=> !switching_enabled) else $error("dis");
	a_foreign_ignored: assert property (cp_wr.valid && cp_wr.reg_num != CCS_SYS_REG_NUM
		|=> $stable(switching_enabled)) else $error("foreign");
	a_switch_low: assert property ($changed(clk_src_is_mem) |-> !core_working_clock) else $error("cut");
	a_mem_phase: assert property (clk_src_is_mem && $rose(core_working_clock) |=> core_working_clock) else $error("mem");
	a_follow_fill: assert property ($changed(clk_src_is_mem) && $past(switching_enabled)
		|-> clk_src_is_mem == $past(cache_fill_pending)) else $error("fill");
	a_miss_mem: assert property ($changed(clk_src_is_mem) && !$past(switching_enabled) |-> clk_src_is_mem)
		else $error("miss");
	cover property (hit && cp_wr.coprocessor_reg_modifier == CCS_CRM_ENABLE);
	cover property ($rose(clk_src_is_mem) && !switching_enabled);
	cover property ($fell(clk_src_is_mem));
endmodule : ccs_chk
bind ccs_core_clock_switch ccs_chk u_ccs_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .cp_wr(cp_wr),
	.cache_fill_pending(cache_fill_pending), .core_working_clock(core_working_clock),
	.clk_src_is_mem(clk_src_is_mem), .switching_enabled(switching_enabled));

/* bench/ccs_core_clock_switch_tb_top.sv */
`timescale 1ns/100ps
module ccs_core_clock_switch_tb_top
	import ccs_pkg::*;
;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [CCS_FREQ_W-1:0] fs = 5'h01;
	ccs_cp_wr_s cp_wr;
	logic fill, ccw, mem, en;
	int bad_count = 0;
	int samples_checked = 0;
	int n;
	initial forever #5 clk_sys = ~clk_sys;
	ccs_core_model u_ccs_core_model (.clk_sys(clk_sys), .cp_wr(cp_wr), .cache_fill_pending(fill));
	ccs_core_clock_switch u_ccs_core_clock_switch (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_freq_select(fs),
		.cp_wr(cp_wr), .cache_fill_pending(fill), .core_working_clock(ccw), .clk_src_is_mem(mem),
		.switching_enabled(en));
	task chk(input string s, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %b got %b", s, e, g);
		end
	endtask : chk
	// High phase length in clk_sys cycles, judged at falling edges
	task hp(input int e);
		@(posedge ccw);
		@(negedge clk_sys);
		n = 0;
		while (ccw === 1'h1) begin
			n++;
			@(negedge clk_sys);
		end
		chk("half", 1'h1, n == e);
	endtask : hp
	task t_fast;
		chk("rst", 1'h1, mem & ~en);
		hp(4);
		u_ccs_core_model.wr(4'hE, CCS_CRM_ENABLE);
		chk("foreign", 1'h0, en);
		u_ccs_core_model.wr(CCS_SYS_REG_NUM, CCS_CRM_ENABLE);
		chk("en", 1'h1, en);
		repeat (20) @(negedge clk_sys);
		chk("fast", 1'h0, mem);
		hp(2);
		@(negedge clk_sys);
		fs = 5'h02;
		repeat (30) @(negedge clk_sys);
		hp(3);
		$display("t_fast done");
	endtask : t_fast
	task t_fill;
		u_ccs_core_model.fill(1'h1);
		repeat (20) @(negedge clk_sys);
		chk("fillmem", 1'h1, mem);
		hp(6);
		u_ccs_core_model.fill(1'h0);
		repeat (20) @(negedge clk_sys);
		chk("back", 1'h0, mem);
		$display("t_fill done");
	endtask : t_fill
	task t_off;
		u_ccs_core_model.wr(CCS_SYS_REG_NUM, 4'h3);
		chk("othercrm", 1'h1, en);
		u_ccs_core_model.wr(CCS_SYS_REG_NUM, CCS_CRM_DISABLE);
		chk("dis", 1'h0, en);
		repeat (20) @(negedge clk_sys);
		chk("frozen", 1'h0, mem);
		u_ccs_core_model.fill(1'h1);
		u_ccs_core_model.fill(1'h0);
		repeat (20) @(negedge clk_sys);
		chk("stay", 1'h1, mem);
		repeat (30) @(negedge clk_sys);
		chk("still", 1'h1, mem);
		u_ccs_core_model.wr(CCS_SYS_REG_NUM, CCS_CRM_ENABLE);
		repeat (30) @(negedge clk_sys);
		chk("refast", 1'h0, mem);
		$display("t_off done");
	endtask : t_off
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'h0;
		repeat (20) @(negedge clk_sys);
		t_fast();
		t_fill();
		t_off();
		summarize();
	end
	// Whole run is a few hundred cycles
	initial begin
		#20000;
		bad_count++;
		summarize();
	end
endmodule : ccs_core_clock_switch_tb_top
